// *** common/itpp_pkg.sv ***
/*
  Shared constants and types of the interval timer programming port.
  Assumes both ends run on one 10 MHz clock.
*/
package itpp_pkg;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int NUM_CNT = 3;
  localparam int PORT_W = 2;
  localparam int MODE_W = 3;
  // Port select code of counter_config_word
  localparam logic [PORT_W-1:0] PORT_CTRL = 2'h3;
  // Control word fields
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int FMT_HI = 5;
  localparam int FMT_LO = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 1;
  localparam int BCD_BIT = 0;
  localparam logic [1:0] SEL_READBACK = 2'h3;
  typedef enum logic [1:0] {
    ITPP_FMT_LATCH,
    ITPP_FMT_LOW,
    ITPP_FMT_HIGH,
    ITPP_FMT_BOTH
  } itpp_fmt_t;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;
  // Host bus timing in clock cycles
  localparam int STROBE_CYC = 3;
  localparam int RECOVER_CYC = 2;
  // Host Wishbone register map
  localparam int WB_ADR_W = 4;
  localparam logic [WB_ADR_W-1:0] WB_CMD_OFF = 4'h0;
  localparam logic [WB_ADR_W-1:0] WB_STAT_OFF = 4'h4;
  localparam int CMD_RD_BIT = 8;
  localparam int CMD_PORT_LO = 9;
  localparam int CMD_PORT_HI = 10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DATA_LO = 8;
endpackage

// *** common/itpp_bus_if.sv ***
/*
  Parallel bus between the host end and the timer end.
  Resolves the shared 8-bit data wire from the two output enables;
  an undriven wire reads as pulled high.
*/
interface itpp_bus_if;
  import itpp_pkg::*;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic port_select_hi;
  logic port_select_lo;
  logic [DATA_W-1:0] host_dout;
  logic host_oe;
  logic [DATA_W-1:0] dev_dout;
  logic dev_oe;
  logic [DATA_W-1:0] data_bus;

  assign data_bus = dev_oe ? dev_dout : (host_oe ? host_dout : BUS_IDLE);

  modport dev (
    input cs_n, rd_n, wr_n, port_select_hi, port_select_lo, data_bus,
    output dev_dout, dev_oe
  );
  modport host (
    output cs_n, rd_n, wr_n, port_select_hi, port_select_lo, host_dout,
    output host_oe,
    input data_bus
  );
endinterface

// *** design/itpp_timer.sv ***
/*
  Timer end: bus decode, counter_config_word, and three counters with
  preset register, counting element and snapshot latch.
  Assumes the host bus runs on clock_i; count clocks and gates are
  asynchronous pins.
*/
// Behaviour
// RULE_01: Port 11 writes go to config word
// RULE_02: Ports 00, 01, 10 address counters
// RULE_03: Strobes ignored unless chip select low
// RULE_04: Drive 8-bit bus only on selected reads
// RULE_05: Config word is write-only, never read
// RULE_06: Counting element 16-bit, not host-accessible
// RULE_07: Snapshot tracks count, freezes after latch
// RULE_08: Reads return one snapshot byte at once
// RULE_09: Preset bytes written singly, transferred together
// RULE_10: Single-byte formats zero the other byte
// RULE_11: Counters undefined until programmed
// RULE_12: Host programs each counter it uses
// RULE_13: Host writes config before count
// RULE_14: Host writes count in configured format
// RULE_15: Counters programmable in any interleaved order
// RULE_16: D7:D6 select counter or read-back (read-back code 11 does nothing here)
// RULE_17: D5:D4 select latch or byte format
// RULE_18: D3:D1 encode modes zero to five (mode is stored in mode_r but changes nothing here)
// RULE_19: D0 selects binary or BCD counting
// RULE_20: Count writes go to addressed counter
// RULE_21: Counters independent, own clock, gate, output
// RULE_22: Per-counter byte pointers reset by config
module itpp_timer (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Host bus
  itpp_bus_if.dev bus,
  // Counter pins
  input wire logic [itpp_pkg::NUM_CNT-1:0] count_clk_i,
  input wire logic [itpp_pkg::NUM_CNT-1:0] gate_i,
  output logic [itpp_pkg::NUM_CNT-1:0] out_o,
  output logic [itpp_pkg::NUM_CNT-1:0] programmed_o
);
  import itpp_pkg::*;

  function automatic logic [CNT_W-1:0] dec_count(
    input logic [CNT_W-1:0] v,
    input logic bcd
  );
    logic [CNT_W-1:0] r;
    logic borrow;
    r = v - CNT_ONE;
    if (bcd) begin
      r = v;
      borrow = 1'b1;
      for (int d = 0; d < CNT_W / 4; d++) begin
        if (borrow) begin
          if (r[d*4 +: 4] == 4'h0) begin
            r[d*4 +: 4] = BCD_NINE;
          end else begin
            r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  logic wr_act;
  logic rd_act;
  logic wr_act_r;
  logic rd_act_r;
  logic wr_evt;
  logic rd_end;
  logic [PORT_W-1:0] port;
  logic [PORT_W-1:0] rd_port_r;
  logic [DATA_W-1:0] din;
  logic cw_wr;
  logic [DATA_W-1:0] counter_config_word_r;
  logic [DATA_W-1:0] dout_r;
  logic oe_r;
  logic [DATA_W-1:0] rd_byte [NUM_CNT];

  assign port = {bus.port_select_hi, bus.port_select_lo};
  assign din = bus.data_bus;
  assign wr_act = !bus.cs_n && !bus.wr_n; // [RULE_03]
  assign rd_act = !bus.cs_n && !bus.rd_n; // [RULE_03]
  assign wr_evt = wr_act && !wr_act_r;
  assign rd_end = rd_act_r && !rd_act;
  assign cw_wr = wr_evt && (port == PORT_CTRL); // [RULE_01]

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
      rd_port_r <= PORT_CTRL;
    end else begin
      wr_act_r <= wr_act;
      rd_act_r <= rd_act;
      if (rd_act && !rd_act_r) begin
        rd_port_r <= port;
      end
    end
  end

  // Write-only; no read path leads here
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      counter_config_word_r <= '0;
    end else if (cw_wr) begin
      counter_config_word_r <= din; // [RULE_01] [RULE_05]
    end
  end

  // Bus driver: only for selected reads of a counter port
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      oe_r <= 1'b0;
      dout_r <= '0;
    end else begin
      oe_r <= rd_act && (port != PORT_CTRL); // [RULE_04] [RULE_05]
      dout_r <= (port == PORT_CTRL) ? '0 : rd_byte[port]; // [RULE_08]
    end
  end

  assign bus.dev_oe = oe_r;
  assign bus.dev_dout = dout_r;

  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    logic cw_hit;
    logic latch_cmd;
    logic cnt_wr;
    logic cnt_rd_end;
    logic [MODE_W-1:0] mode_r;
    logic bcd_r;
    itpp_fmt_t fmt_r;
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [CNT_W-1:0] preset_register_r;
    logic load_r;
    logic [CNT_W-1:0] ce_r;
    logic [CNT_W-1:0] count_snapshot_latch_r;
    logic latched_r;
    logic programmed_r;
    logic out_r;
    logic clk_s1_r;
    logic clk_s2_r;
    logic clk_s3_r;
    logic gate_s1_r;
    logic gate_s2_r;
    logic tick;

    assign cw_hit = cw_wr && (din[SEL_HI:SEL_LO] == PORT_W'(i)) &&
                    (din[FMT_HI:FMT_LO] != ITPP_FMT_LATCH); // [RULE_16]
    assign latch_cmd = cw_wr && (din[SEL_HI:SEL_LO] == PORT_W'(i)) &&
                       (din[FMT_HI:FMT_LO] == ITPP_FMT_LATCH); // [RULE_17]
    assign cnt_wr = wr_evt && (port == PORT_W'(i)); // [RULE_02] [RULE_20]
    assign cnt_rd_end = rd_end && (rd_port_r == PORT_W'(i)); // [RULE_02]
    assign tick = clk_s2_r && !clk_s3_r && gate_s2_r;

    // Snapshot byte offered to the internal bus
    always_comb begin
      case (fmt_r)
        ITPP_FMT_HIGH: rd_byte[i] = count_snapshot_latch_r[CNT_W-1:DATA_W];
        ITPP_FMT_BOTH: rd_byte[i] = rd_ptr_r ?
          count_snapshot_latch_r[CNT_W-1:DATA_W] :
          count_snapshot_latch_r[DATA_W-1:0]; // [RULE_08]
        default: rd_byte[i] = count_snapshot_latch_r[DATA_W-1:0];
      endcase
    end

    // Configuration of this counter only
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        mode_r <= '0;
        bcd_r <= 1'b0;
        fmt_r <= ITPP_FMT_LOW;
      end else if (cw_hit) begin
        mode_r <= din[MODE_HI:MODE_LO]; // [RULE_18]
        bcd_r <= din[BCD_BIT]; // [RULE_19]
        fmt_r <= itpp_fmt_t'(din[FMT_HI:FMT_LO]); // [RULE_17] [RULE_15]
      end
    end

    // Byte pointers for two-byte format
    always_ff @(posedge clock_i) begin
      if (srst_i || cw_hit) begin
        wr_ptr_r <= 1'b0; // [RULE_22]
        rd_ptr_r <= 1'b0; // [RULE_22]
      end else begin
        if (cnt_wr && fmt_r == ITPP_FMT_BOTH) begin
          wr_ptr_r <= !wr_ptr_r; // [RULE_22]
        end
        if (cnt_rd_end && fmt_r == ITPP_FMT_BOTH) begin
          rd_ptr_r <= !rd_ptr_r; // [RULE_22]
        end
      end
    end

    // Preset register, loaded a byte at a time
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        preset_register_r <= '0;
        load_r <= 1'b0;
      end else begin
        load_r <= 1'b0;
        if (cnt_wr) begin
          case (fmt_r)
            ITPP_FMT_LOW: begin
              preset_register_r <= {{DATA_W{1'b0}}, din}; // [RULE_10]
              load_r <= 1'b1;
            end
            ITPP_FMT_HIGH: begin
              preset_register_r <= {din, {DATA_W{1'b0}}}; // [RULE_10]
              load_r <= 1'b1;
            end
            ITPP_FMT_BOTH: begin
              if (wr_ptr_r) begin
                preset_register_r[CNT_W-1:DATA_W] <= din; // [RULE_09]
                load_r <= 1'b1;
              end else begin
                preset_register_r[DATA_W-1:0] <= din; // [RULE_09]
              end
            end
            default: load_r <= 1'b0;
          endcase
        end
      end
    end

    // Count pin synchronisers
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        clk_s1_r <= 1'b0;
        clk_s2_r <= 1'b0;
        clk_s3_r <= 1'b0;
        gate_s1_r <= 1'b0;
        gate_s2_r <= 1'b0;
      end else begin
        clk_s1_r <= count_clk_i[i];
        clk_s2_r <= clk_s1_r;
        clk_s3_r <= clk_s2_r;
        gate_s1_r <= gate_i[i];
        gate_s2_r <= gate_s1_r;
      end
    end

    // Counting element: preset as a whole, then counts down
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        ce_r <= '0;
        programmed_r <= 1'b0;
      end else if (cw_hit) begin
        programmed_r <= 1'b0; // [RULE_11]
      end else if (load_r) begin
        ce_r <= preset_register_r; // [RULE_09] [RULE_06]
        programmed_r <= 1'b1; // [RULE_11]
      end else if (tick && programmed_r) begin
        ce_r <= dec_count(ce_r, bcd_r); // [RULE_06] [RULE_19] [RULE_21]
      end
    end

    // Snapshot latch follows the count unless frozen
    always_ff @(posedge clock_i) begin
      if (srst_i || cw_hit) begin
        latched_r <= 1'b0; // [RULE_07]
      end else if (latch_cmd && !latched_r) begin
        latched_r <= 1'b1; // [RULE_07]
      end else if (cnt_rd_end &&
                   (fmt_r != ITPP_FMT_BOTH || rd_ptr_r)) begin
        latched_r <= 1'b0; // [RULE_07]
      end
    end

    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        count_snapshot_latch_r <= '0;
      end else if (!latched_r && !(latch_cmd && !latched_r)) begin
        count_snapshot_latch_r <= ce_r; // [RULE_07]
      end
    end

    // Output: high while a programmed count is zero
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        out_r <= 1'b0;
      end else begin
        out_r <= programmed_r && (ce_r == CNT_ZERO); // [RULE_21]
      end
    end

    assign out_o[i] = out_r;
    assign programmed_o[i] = programmed_r;
  end

endmodule // itpp_timer

// *** design/itpp_host.sv ***
/*
  Host end: a classic Wishbone slave whose command register starts one
  read or write cycle on the timer's parallel bus.
  Assumes the timer runs on the same clock_i.
*/
module itpp_host (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [itpp_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer bus
  itpp_bus_if.host bus
);
  import itpp_pkg::*;

  typedef enum logic [1:0] {
    ITPP_IDLE,
    ITPP_STROBE,
    ITPP_RECOVER
  } itpp_hstate_t;

  itpp_hstate_t state_r;
  logic [2:0] cnt_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [10:0] cmd_r;
  logic [DATA_W-1:0] rdata_r;
  logic cs_n_r;
  logic rd_n_r;
  logic wr_n_r;
  logic [PORT_W-1:0] ps_r;
  logic [DATA_W-1:0] hdout_r;
  logic hoe_r;
  logic req;
  logic start;
  logic busy;

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign busy = (state_r != ITPP_IDLE);
  assign start = req && wb_we_i && (wb_adr_i == WB_CMD_OFF) &&
                 (wb_sel_i[1:0] == 2'b11) && !busy;

  // Wishbone answer one cycle after the request
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= req;
      dat_r <= '0;
      if (req && !wb_we_i && wb_adr_i == WB_CMD_OFF) begin
        dat_r[10:0] <= cmd_r;
      end else if (req && !wb_we_i && wb_adr_i == WB_STAT_OFF) begin
        dat_r[STAT_BUSY_BIT] <= busy;
        dat_r[STAT_DATA_LO +: DATA_W] <= rdata_r;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cmd_r <= '0;
    end else if (start) begin
      cmd_r <= wb_dat_i[10:0];
    end
  end

  // Bus cycle sequencer
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_r <= ITPP_IDLE;
      cnt_r <= '0;
      cs_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      ps_r <= '0;
      hdout_r <= '0;
      hoe_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      case (state_r)
        ITPP_IDLE: begin
          cnt_r <= '0;
          if (start) begin
            state_r <= ITPP_STROBE;
            cs_n_r <= 1'b0; // [RULE_03]
            ps_r <= wb_dat_i[CMD_PORT_HI:CMD_PORT_LO]; // [RULE_13] [RULE_14]
            rd_n_r <= !wb_dat_i[CMD_RD_BIT];
            wr_n_r <= wb_dat_i[CMD_RD_BIT];
            hoe_r <= !wb_dat_i[CMD_RD_BIT];
            hdout_r <= wb_dat_i[DATA_W-1:0]; // [RULE_18]
          end
        end
        ITPP_STROBE: begin
          cnt_r <= cnt_r + 3'd1;
          if (cnt_r == 3'(STROBE_CYC - 1)) begin
            if (!rd_n_r) begin
              rdata_r <= bus.data_bus;
            end
            cs_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            hoe_r <= 1'b0;
            cnt_r <= '0;
            state_r <= ITPP_RECOVER;
          end
        end
        ITPP_RECOVER: begin
          cnt_r <= cnt_r + 3'd1;
          if (cnt_r == 3'(RECOVER_CYC - 1)) begin
            state_r <= ITPP_IDLE;
          end
        end
        default: state_r <= ITPP_IDLE;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign bus.cs_n = cs_n_r;
  assign bus.rd_n = rd_n_r;
  assign bus.wr_n = wr_n_r;
  assign bus.port_select_hi = ps_r[1];
  assign bus.port_select_lo = ps_r[0];
  assign bus.host_dout = hdout_r;
  assign bus.host_oe = hoe_r;

endmodule // itpp_host

// *** verification/itpp_checker.sv ***
/*
  Concurrent checks on the parallel bus between host end and timer end.
  Assumes one clock domain and the interface signals wired in by name.
*/
module itpp_checker (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Bus signals
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_select_hi,
  input wire logic port_select_lo,
  input wire logic [itpp_pkg::DATA_W-1:0] host_dout,
  input wire logic host_oe,
  input wire logic dev_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import itpp_pkg::*;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  sequence s_strobe;
    !cs_n [*3];
  endsequence
  sequence s_recover;
    cs_n [*2];
  endsequence

  AST_STROBE_FRAME: assert property (
    $fell(cs_n) |-> s_strobe ##1 s_recover)
    else $error("strobe or recovery length wrong");
  AST_OE_CAUSE: assert property (
    dev_oe |-> !$past(cs_n) && !$past(rd_n))
    else $error("timer drives bus without a selected read");
  AST_OE_ANSWER: assert property (
    (!cs_n && !rd_n && !(port_select_hi && port_select_lo)) |=> dev_oe)
    else $error("timer did not answer a selected read");
  AST_CTRL_NO_READ: assert property (
    (port_select_hi && port_select_lo) [*2] |-> !dev_oe)
    else $error("config word address drove the bus");
  AST_OE_RELEASE: assert property (
    rd_n [*2] |-> !dev_oe)
    else $error("timer kept driving after the read");
  AST_NO_CONTEND: assert property (
    !(host_oe && dev_oe))
    else $error("both ends drive the data bus");
  AST_ONE_STROBE: assert property (
    (!rd_n || !wr_n) |-> !cs_n && (rd_n || wr_n))
    else $error("strobe without select or both strobes low");
  AST_WR_HOLD: assert property (
    (!wr_n && !$past(wr_n)) |-> host_oe && $stable(host_dout))
    else $error("write data moved during the strobe");
  AST_PORT_HOLD: assert property (
    (!cs_n && !$past(cs_n)) |-> $stable({port_select_hi, port_select_lo}))
    else $error("port select moved during the access");
endmodule // itpp_checker

// *** verification/testbench.sv ***
/*
  Self-checking bench: host end and timer end joined by the bus
  interface, driven through classic Wishbone cycles on the host end.
  Assumes a 10 MHz clock and the command and status map of the host.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import itpp_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [WB_ADR_W-1:0] wb_adr = '0;
  logic [31:0] wb_wdat = '0;
  logic [3:0] wb_sel = '0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [NUM_CNT-1:0] count_clk = '0;
  logic [NUM_CNT-1:0] gate = '1;
  logic [NUM_CNT-1:0] out;
  logic [NUM_CNT-1:0] progd;
  int n_mismatch = 0;
  int n_tests = 0;

  always #50 clock_i = ~clock_i;

  itpp_bus_if bus_if ();
  itpp_host i_itpp_host (.clock_i(clock_i), .srst_i(srst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .bus(bus_if.host));
  itpp_timer i_itpp_timer (.clock_i(clock_i), .srst_i(srst_i),
    .bus(bus_if.dev), .count_clk_i(count_clk), .gate_i(gate),
    .out_o(out), .programmed_o(progd));
  itpp_checker i_itpp_checker (.clock_i(clock_i), .srst_i(srst_i),
    .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n),
    .port_select_hi(bus_if.port_select_hi),
    .port_select_lo(bus_if.port_select_lo),
    .host_dout(bus_if.host_dout), .host_oe(bus_if.host_oe),
    .dev_oe(bus_if.dev_oe));

  task automatic give_verdict();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic fail(input string s);
    n_mismatch++;
    $display("MISMATCH t=%0t %s", $time, s);
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
  endtask

  // One classic cycle; returns at the edge where ack is seen
  task automatic wb_xfer(input logic we, input logic [WB_ADR_W-1:0] adr,
                         input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hF;
    wb_wdat <= d;
    do begin
      @(posedge clock_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50) begin
      fail("wishbone timeout");
      give_verdict();
    end
  endtask

  // One timer bus access through the command register, then poll busy
  task automatic bus_op(input logic rd, input logic [1:0] port,
                        input logic [7:0] d, output logic [7:0] q);
    logic [31:0] t;
    int n;
    wb_xfer(1'b1, WB_CMD_OFF, {21'h0, port, rd, d}, t);
    n = 0;
    do begin
      wb_xfer(1'b0, WB_STAT_OFF, '0, t);
      n++;
    end while (t[STAT_BUSY_BIT] !== 1'b0 && n < 40);
    if (n >= 40) begin
      fail("bus cycle timeout");
      give_verdict();
    end
    q = t[15:8];
  endtask

  task automatic wr(input logic [1:0] port, input logic [7:0] d);
    logic [7:0] q;
    bus_op(1'b0, port, d, q);
  endtask

  task automatic rd_chk(input logic [1:0] port, input logic [7:0] exp);
    logic [7:0] q;
    bus_op(1'b1, port, 8'h00, q);
    check_byte(q, exp);
  endtask

  // Count clock edges slow enough for the two-flop synchroniser
  task automatic pulse(input int i, input int k);
    logic [NUM_CNT-1:0] m;
    m = '0;
    m[i] = 1'b1;
    repeat (k) begin
      count_clk <= count_clk | m;
      repeat (4) @(posedge clock_i);
      count_clk <= count_clk & ~m;
      repeat (4) @(posedge clock_i);
    end
  endtask

  initial begin
    logic [31:0] q;
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    wr(2'h3, 8'h34);
    wr(2'h3, 8'hA0);
    wr(2'h0, 8'h99);
    wr(2'h3, 8'h34);
    wr(2'h0, 8'h12);
    check_bit(progd[0], 1'b0);
    wr(2'h2, 8'h77);
    wr(2'h0, 8'hAB);
    check_bit(progd[0], 1'b1);
    rd_chk(2'h0, 8'h12);
    rd_chk(2'h0, 8'hAB);
    rd_chk(2'h2, 8'h77);
    rd_chk(2'h3, BUS_IDLE);
    wr(2'h3, 8'hCE);
    check_bit(progd[0], 1'b1);
    // Latch, then a second latch that must be ignored
    pulse(0, 1);
    wr(2'h3, 8'h00);
    pulse(0, 1);
    wr(2'h3, 8'h00);
    pulse(0, 1);
    rd_chk(2'h0, 8'h11);
    rd_chk(2'h0, 8'hAB);
    gate[0] <= 1'b0;
    pulse(0, 2);
    gate[0] <= 1'b1;
    rd_chk(2'h0, 8'h0F);
    rd_chk(2'h0, 8'hAB);
    // Low byte only: high byte must be zero for the count to expire
    wr(2'h3, 8'h50);
    wr(2'h1, 8'h03);
    pulse(1, 2);
    check_bit(out[1], 1'b0);
    pulse(1, 1);
    check_bit(out[1], 1'b1);
    pulse(1, 1);
    rd_chk(2'h1, 8'hFF);
    rd_chk(2'h2, 8'h77);
    wr(2'h3, 8'h51);
    wr(2'h1, 8'h01);
    pulse(1, 2);
    rd_chk(2'h1, 8'h99);
    for (int m = 0; m < 6; m++) begin
      wr(2'h3, {4'hA, 3'(m), 1'b0});
      check_bit(progd[2], 1'b0);
      wr(2'h2, 8'h40 + 8'(m));
      rd_chk(2'h2, 8'h40 + 8'(m));
    end
    wb_xfer(1'b0, 4'h8, '0, q);
    check_word(q, 32'h0000_0000);
    wb_xfer(1'b0, WB_CMD_OFF, '0, q);
    check_word(q, 32'h0000_0500);
    check_byte({5'h0, out}, 8'h00);
    check_byte({5'h0, progd}, 8'h07);
    // Reset in mid-run: every counter must fall back to unprogrammed
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    check_byte({5'h0, progd}, 8'h00);
    check_byte({5'h0, out}, 8'h00);
    wr(2'h3, 8'h10);
    wr(2'h0, 8'h05);
    rd_chk(2'h0, 8'h05);
    check_bit(progd[0], 1'b1);
    give_verdict();
  end
endmodule // testbench
